// File: design/general_purpose_pin_port.sv
// General-purpose pin port: direction, drive, pulldowns, edge flags
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Each pin selectable as input or output.
// - Output pin drives the software output bit.
// - Input register shows sampled pin level.
// - 26 two-way pins plus one output.
// - Per-pin pulldown, on by default, disable bit.
// - Per-pin edge interrupt, rising or falling.
// - Some sampled inputs feed timer clocks.
// - Two-cycle active pulse is captured as flag.
// - Output level held at least three cycles.
// - Latency at least 5, 7, 8 cycles.
module general_purpose_pin_port
    import gpio_port_pkg::*;
(
    // Clock and reset
    input  wire logic                     mclk,
    input  wire logic                     rst_n,
    // Software control
    input  wire pin_ctrl_type             ctrl,
    input  wire logic [NUM_PINS-1:0]      flag_clear,
    input  wire logic                     extra_out_value,
    // Pins
    input  wire logic [NUM_PINS-1:0]      pin_in,
    output var  logic [NUM_PINS-1:0]      pin_out,
    output var  logic [NUM_PINS-1:0]      pin_oe,
    output var  logic [NUM_PINS-1:0]      pin_pulldown,
    output var  logic                     extra_output_pin,
    // Status and events
    output var  pin_status_type           status,
    output var  logic                     cpu_irq,
    output var  logic [NUM_TIMER_CLK-1:0] timer_clock
);

    logic                      rst_meta;
    logic                      rst_ok;
    logic [NUM_PINS-1:0]       sync1;
    logic [NUM_PINS-1:0]       sync2;
    logic [NUM_PINS-1:0]       sync3;
    logic [NUM_PINS-1:0]       filt;
    logic [NUM_PINS-1:0]       filt_prev;
    logic [NUM_PINS-1:0]       edge_hit;
    logic [NUM_PINS-1:0]       edge_pipe [EDGE_STAGES];
    logic [NUM_PINS-1:0]       din;
    logic [NUM_PINS-1:0]       flags;
    logic [NUM_DRIVEN-1:0]     drv;
    logic [NUM_DRIVEN-1:0]     want;
    logic [HOLD_W-1:0]         hold_cnt [NUM_DRIVEN];

    // Checks run on the released reset only; a check that spans
    // reset would compare against flops held at their reset values
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_ok);

    // Reset release through two flops; assertion is immediate
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'h0;
            rst_ok   <= 1'h0;
        end else begin
            rst_meta <= 1'h1;
            rst_ok   <= rst_meta;
        end
    end

    // Pin synchroniser; the first stage feeds only the second
    always_ff @(posedge mclk or negedge rst_ok) begin
        if (!rst_ok) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= pin_in;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Accept a level only once stages two and three agree, so a
    // one-cycle glitch is dropped and a two-cycle pulse is kept
    always_ff @(posedge mclk or negedge rst_ok) begin
        if (!rst_ok) begin
            filt      <= '0;
            filt_prev <= '0;
        end else begin
            for (int i = 0; i < NUM_PINS; i++) begin
                if (sync2[i] == sync3[i]) begin
                    filt[i] <= sync3[i];
                end
            end
            filt_prev <= filt;
        end
    end

    // Samples that still disagree must not move the accepted level,
    // otherwise a one-cycle glitch would reach the flags
    a_glitch_drop: assert property (
        (sync2[0] != sync3[0]) |=> $stable(filt[0]))
        else $error("filtered level moved on disagreeing samples");

    // Input data register; pad is read whatever the direction
    always_ff @(posedge mclk or negedge rst_ok) begin
        if (!rst_ok) begin
            din <= '0;
        end else begin
            din <= filt;
        end
    end

    // Input data is the accepted level one cycle later
    a_din_follow: assert property (
        ##1 din == $past(filt))
        else $error("input data does not follow filtered level");

    // A new level never shows before its pad has stood two samples
    a_din_latency: assert property (
        $rose(din[0]) |-> ($past(pin_in[0], 5) && $past(pin_in[0], 4)))
        else $error("input data changed too early");

    // Per-pin edge choice
    always_comb begin
        edge_hit = (ctrl.rise_sel & filt & ~filt_prev) |
                   (~ctrl.rise_sel & ~filt & filt_prev);
    end

    // Delay edges so flags never appear before their latency
    always_ff @(posedge mclk or negedge rst_ok) begin
        if (!rst_ok) begin
            for (int s = 0; s < EDGE_STAGES; s++) begin
                edge_pipe[s] <= '0;
            end
        end else begin
            edge_pipe[0] <= edge_hit;
            for (int s = 1; s < EDGE_STAGES; s++) begin
                edge_pipe[s] <= edge_pipe[s-1];
            end
        end
    end

    // Sticky flags; a new edge beats a clear in the same cycle
    always_ff @(posedge mclk or negedge rst_ok) begin
        if (!rst_ok) begin
            flags <= '0;
        end else begin
            flags <= (flags & ~flag_clear) |
                     edge_pipe[EDGE_STAGES-1];
        end
    end

    // A new edge must land even when a clear is held
    a_set_wins: assert property (
        edge_pipe[EDGE_STAGES-1][0] |=> flags[0])
        else $error("captured edge lost against clear");

    // Flags hold until software clears them
    a_flag_sticky: assert property (
        (flags[0] && !flag_clear[0]) |=> flags[0])
        else $error("flag dropped without clear");

    // A clear with no edge in flight empties the flag
    a_flag_clear: assert property (
        (flag_clear[7] && !edge_pipe[EDGE_STAGES-1][7]) |=> !flags[7])
        else $error("flag survived a clear");

    // Level history three and two cycles before a new flag
    sequence s_rise_seen;
        !$past(din[0], 3) ##0 $past(din[0], 2);
    endsequence

    sequence s_fall_seen;
        $past(din[7], 3) ##0 !$past(din[7], 2);
    endsequence

    a_flag_rise: assert property (
        ($rose(flags[0]) && $past(ctrl.rise_sel[0], 3) &&
         !$past(flag_clear[0])) |-> s_rise_seen)
        else $error("rising flag without rising input");

    // Falling choice is watched on the pin the tests toggle both ways
    a_flag_fall: assert property (
        ($rose(flags[7]) && !$past(ctrl.rise_sel[7], 3) &&
         !$past(flag_clear[7])) |-> s_fall_seen)
        else $error("falling flag without falling input");

    // Interrupt request, one flop after the flags
    always_ff @(posedge mclk or negedge rst_ok) begin
        if (!rst_ok) begin
            cpu_irq <= 1'h0;
        end else begin
            cpu_irq <= |(flags & ctrl.irq_en);
        end
    end

    // Request is the enabled flags one cycle late
    a_irq_follow: assert property (
        ##1 cpu_irq == |($past(flags) & $past(ctrl.irq_en)))
        else $error("interrupt does not follow enabled flags");

    // Status readback
    always_comb begin
        status.input_data            = din;
        status.edge_capture_flag_reg = flags;
    end

    // Timer clock taps from filtered inputs
    always_ff @(posedge mclk or negedge rst_ok) begin
        if (!rst_ok) begin
            timer_clock <= '0;
        end else begin
            for (int t = 0; t < NUM_TIMER_CLK; t++) begin
                timer_clock[t] <= filt[TIMER_PIN[t]];
            end
        end
    end

    // Timers see the filtered pad, never the raw one
    a_timer_tap: assert property (
        ##1 timer_clock[0] == $past(filt[TIMER_PIN[0]]))
        else $error("timer clock tap wrong");

    // Direction and pulldown controls, registered to the pads
    always_ff @(posedge mclk or negedge rst_ok) begin
        if (!rst_ok) begin
            pin_oe       <= DIR_RESET;
            pin_pulldown <= PD_RESET;
        end else begin
            pin_oe       <= ctrl.dir;
            pin_pulldown <= ~ctrl.pulldown_off;
        end
    end

    // Pad controls follow software one cycle late
    a_dir_to_oe: assert property (
        ##1 pin_oe == $past(ctrl.dir))
        else $error("output enable does not follow direction");

    // Pulldown is on unless its disable bit is set
    a_pulldown_ctl: assert property (
        ##1 pin_pulldown == ~$past(ctrl.pulldown_off))
        else $error("pulldown does not follow control");

    // Requested levels: the 26 pins and the extra output on top
    always_comb begin
        want = {extra_out_value, ctrl.out_value};
    end

    // Output drive with minimum level time; a request arriving
    // early is not lost, it is taken once the hold expires
    always_ff @(posedge mclk or negedge rst_ok) begin
        if (!rst_ok) begin
            drv <= '0;
            for (int i = 0; i < NUM_DRIVEN; i++) begin
                hold_cnt[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_DRIVEN; i++) begin
                if (hold_cnt[i] != '0) begin
                    hold_cnt[i] <= hold_cnt[i] - 1'h1;
                end else if (want[i] != drv[i]) begin
                    drv[i]      <= want[i];
                    hold_cnt[i] <= HOLD_W'(OUT_HOLD_CYCLES - 1);
                end
            end
        end
    end

    // Pad drive values
    always_comb begin
        pin_out          = drv[NUM_PINS-1:0];
        extra_output_pin = drv[NUM_PINS];
    end

    // Helper: no pin is inside its hold time
    logic all_free;
    always_comb begin
        all_free = 1'h1;
        for (int i = 0; i < NUM_PINS; i++) begin
            if (hold_cnt[i] != '0) begin
                all_free = 1'h0;
            end
        end
    end

    // Free pins take the software level at the next edge
    a_out_follow: assert property (
        (all_free && ctrl.out_value != drv[NUM_PINS-1:0]) |=>
        pin_out == $past(ctrl.out_value))
        else $error("output pin missed software value");

    // Watched on the top pin, which the tests drive as an output
    a_out_hold: assert property (
        $changed(pin_out[NUM_PINS-1]) |=> $stable(pin_out[NUM_PINS-1]) [*2])
        else $error("output level held under three cycles");

    // Dedicated output has its own counter and the same hold
    a_extra_hold: assert property (
        $changed(extra_output_pin) |=> $stable(extra_output_pin) [*2])
        else $error("extra output held under three cycles");

endmodule : general_purpose_pin_port

`default_nettype wire

// File: design/gpio_port_pkg.sv
// Shared constants and carrier types of the general-purpose pin port
package gpio_port_pkg;

    // Pin counts
    localparam int NUM_PINS      = 26;
    localparam int NUM_DRIVEN    = NUM_PINS + 1;
    localparam int NUM_TIMER_CLK = 3;

    // System clock period
    localparam int CLK_PERIOD_NS = 10;

    // Least output level time, in ns, and as whole cycles rounded up
    localparam int OUT_HOLD_NS     = 30;
    localparam int OUT_HOLD_CYCLES =
        (OUT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_W          = $clog2(OUT_HOLD_CYCLES + 1);

    // Input path latencies in cycles
    localparam int DIN_LATENCY  = 5;
    localparam int FLAG_LATENCY = 7;
    localparam int IRQ_LATENCY  = 8;
    // Edge pulse delay stages between input register and flags
    localparam int EDGE_STAGES  = FLAG_LATENCY - DIN_LATENCY;

    // Pins that double as timer clock sources
    localparam int TIMER_PIN [NUM_TIMER_CLK] = '{0, 1, 2};

    // Reset values
    localparam logic [NUM_PINS-1:0] DIR_RESET = '0;
    localparam logic [NUM_PINS-1:0] PD_RESET  = '1;

    // Software control bits, one per pin in each field
    typedef struct packed {
        logic [NUM_PINS-1:0] dir;          // 1 = output
        logic [NUM_PINS-1:0] out_value;
        logic [NUM_PINS-1:0] pulldown_off;
        logic [NUM_PINS-1:0] rise_sel;     // 1 = rising, 0 = falling
        logic [NUM_PINS-1:0] irq_en;
    } pin_ctrl_type;

    // State that software reads back
    typedef struct packed {
        logic [NUM_PINS-1:0] input_data;
        logic [NUM_PINS-1:0] edge_capture_flag_reg;
    } pin_status_type;

endpackage : gpio_port_pkg

// File: dv/pin_partner.sv
// External circuitry model for the general-purpose pins
`timescale 1ns/1ns
`default_nettype none
module pin_partner
    import gpio_port_pkg::*;
(
    // Clock and pads
    input  wire logic                mclk,
    input  wire logic [NUM_PINS-1:0] pin_out,
    input  wire logic [NUM_PINS-1:0] pin_oe,
    input  wire logic [NUM_PINS-1:0] pin_pulldown,
    output var  logic [NUM_PINS-1:0] pin_in
);
    logic [NUM_PINS-1:0] ext_en  = '0;
    logic [NUM_PINS-1:0] ext_val = '0;
    logic [NUM_PINS-1:0] wander  = '0;

    // A floating pad changes every cycle so no stale level is read
    always @(posedge mclk) wander <= ~wander;

    // Port drive first, then our driver, then pulldown or float
    always_comb begin
        pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
               | (~pin_oe & ~ext_en & ~pin_pulldown & wander);
    end

    // New level after a falling edge, held two cycles at least
    task automatic drive_pin(input int idx, input logic lvl);
        @(negedge mclk);
        ext_en[idx]  = 1'b1;
        ext_val[idx] = lvl;
        repeat (2) @(negedge mclk);
    endtask : drive_pin
endmodule : pin_partner
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the general-purpose pin port
`timescale 1ns/1ns
`default_nettype none
module testbench
    import gpio_port_pkg::*;
;
    logic                     mclk = 1'b0;
    logic                     rst_n = 1'b0;
    pin_ctrl_type             ctrl = '0;
    logic [NUM_PINS-1:0]      flag_clear = '0;
    logic                     extra_out_value = 1'b0;
    logic [NUM_PINS-1:0]      pin_in, pin_out, pin_oe, pin_pulldown;
    logic                     extra_output_pin, cpu_irq;
    pin_status_type           status;
    logic [NUM_TIMER_CLK-1:0] timer_clock;
    int                       err_total = 0;
    int                       n_checks = 0;

    // 100 MHz system clock
    always #5 mclk = ~mclk;

    general_purpose_pin_port i_dut (
        .mclk(mclk), .rst_n(rst_n), .ctrl(ctrl), .flag_clear(flag_clear),
        .extra_out_value(extra_out_value), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_pulldown(pin_pulldown),
        .extra_output_pin(extra_output_pin), .status(status),
        .cpu_irq(cpu_irq), .timer_clock(timer_clock));

    pin_partner i_partner (
        .mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pulldown(pin_pulldown), .pin_in(pin_in));

    task automatic complete_run;
        if (err_total == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    // Pin index -1 stands for the dedicated output
    function automatic logic drv(input int pin);
        return (pin < 0) ? extra_output_pin : pin_out[pin];
    endfunction : drv

    // Raise an output, ask it straight back down, count how long it stays
    task automatic out_hold(input int pin);
        int len;
        len = 0;
        if (pin < 0) extra_out_value = 1'b1;
        else ctrl.out_value[pin] = 1'b1;
        @(negedge mclk);
        check("out rise", 32'(drv(pin)), 1);
        if (pin < 0) extra_out_value = 1'b0;
        else ctrl.out_value[pin] = 1'b0;
        while (drv(pin) === 1'b1 && len < 10) begin
            len++;
            @(negedge mclk);
        end
        check("out hold", len, OUT_HOLD_CYCLES);
    endtask : out_hold

    // Drive a pin level, record first cycle of data, flag and interrupt
    task automatic in_lat(input int pin, input logic lvl,
                          input logic fl, input logic irq);
        int t_din, t_flag, t_irq;
        t_din = 0;
        t_flag = 0;
        t_irq = 0;
        i_partner.drive_pin(pin, lvl);
        for (int t = 3; t <= 12; t++) begin
            @(negedge mclk);
            if (t_din == 0 && status.input_data[pin] === lvl) t_din = t;
            if (t_flag == 0 && status.edge_capture_flag_reg[pin] === 1'b1)
                t_flag = t;
            if (t_irq == 0 && cpu_irq === 1'b1) t_irq = t;
        end
        check("din latency", t_din, DIN_LATENCY);
        check("flag latency", t_flag, fl ? FLAG_LATENCY : 0);
        check("irq latency", t_irq, irq ? IRQ_LATENCY : 0);
    endtask : in_lat

    task automatic clear_flag(input int pin);
        flag_clear[pin] = 1'b1;
        @(negedge mclk);
        flag_clear[pin] = 1'b0;
        @(negedge mclk);
        check("flag clear", 32'(status.edge_capture_flag_reg[pin]),
              0);
        check("irq clear", 32'(cpu_irq), 0);
    endtask : clear_flag

    // Main sequence: reset, outputs, pulldowns, edges, timer tap
    initial begin
        repeat (20) @(negedge mclk);
        check("rst pulldown", 32'(pin_pulldown), 32'(PD_RESET));
        check("rst oe", 32'(pin_oe), 32'(DIR_RESET));
        check("rst irq", 32'(cpu_irq), 0);
        rst_n = 1'b1;
        repeat (3) @(negedge mclk);
        ctrl.dir[25] = 1'b1;
        @(negedge mclk);
        check("oe pin 25", 32'(pin_oe), 32'h0200_0000);
        out_hold(25);
        out_hold(-1);
        ctrl.pulldown_off[5] = 1'b1;
        @(negedge mclk);
        check("pulldown", 32'(pin_pulldown), 32'h03FF_FFDF);
        ctrl.rise_sel[7] = 1'b1;
        ctrl.irq_en[7] = 1'b1;
        in_lat(7, 1'b1, 1'b1, 1'b1);
        clear_flag(7);
        in_lat(7, 1'b0, 1'b0, 1'b0);
        ctrl.rise_sel[7] = 1'b0;
        in_lat(7, 1'b1, 1'b0, 1'b0);
        in_lat(7, 1'b0, 1'b1, 1'b1);
        clear_flag(7);
        ctrl.irq_en[7] = 1'b0;
        in_lat(7, 1'b1, 1'b0, 1'b0);
        in_lat(7, 1'b0, 1'b1, 1'b0);
        clear_flag(7);
        ctrl.rise_sel[0] = 1'b1;
        in_lat(0, 1'b1, 1'b1, 1'b0);
        check("timer tap", 32'(timer_clock), 1);
        complete_run();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #100000;
        err_total++;
        complete_run();
    end
endmodule : testbench
`default_nettype wire
